// >>> src/sch_pkg.sv
// package: constants and types for the supervisory command handler
package sch_pkg;
  // ==========================================================
  // command codes
  localparam logic [7:0] CMD_RECAL     = 8'h62;
  localparam logic [7:0] CMD_LAST      = 8'h6C;
  localparam logic [7:0] CMD_RESET     = 8'h72;
  localparam logic [7:0] CMD_VERSION   = 8'h56;
  localparam logic [7:0] CMD_SIGNATURE = 8'h57;
  localparam logic [7:0] CMD_SLEEP     = 8'h5A;
  localparam logic [7:0] CMD_RATE      = 8'h11;
  localparam logic [7:0] CMD_SCOPESYNC = 8'h12;
  localparam logic [7:0] CMD_NOISESYNC = 8'h17;
  localparam logic [7:0] CMD_PUT       = 8'h70;
  localparam logic [7:0] CMD_GET       = 8'h67;
  localparam logic [7:0] NULL_BYTE     = 8'h00;
  // ==========================================================
  // operand limits and reset values
  localparam logic [7:0] RATE_MAX_SPI  = 8'h03;
  localparam logic [7:0] RATE_MAX_UART = 8'h04;
  localparam logic [2:0] RATE_RST      = 3'h0;
  localparam logic       SCOPESYNC_RST = 1'b0;
  localparam logic       NOISESYNC_RST = 1'b0;
  localparam logic       PUT_MODE_RST  = 1'b0;
  localparam logic [7:0] LAST_RST      = 8'h00;
  // ==========================================================
  // timing
  localparam longint CLK_HZ        = 25_000_000;
  localparam longint OPERAND_US    = 100_000;
  localparam longint RESET_DLY_US  = 16_000;
  localparam longint SLEEP_TO_US   = 2_000_000;
  localparam longint WAKE_LOW_NS   = 10_000;
  localparam int OPERAND_CYC   = int'(CLK_HZ * OPERAND_US / 1_000_000);
  localparam int RESET_DLY_CYC = int'(CLK_HZ * RESET_DLY_US / 1_000_000);
  localparam int SLEEP_TO_CYC  = int'(CLK_HZ * SLEEP_TO_US / 1_000_000);
  localparam int WAKE_LOW_CYC  = int'((CLK_HZ * WAKE_LOW_NS + 999_999_999) / 1_000_000_000);
  // ==========================================================
  // carriers
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } sch_byte_t;

  typedef struct packed {
    logic [2:0] rate;
    logic       noise_sync;
  } sch_boot_cfg_t;
endpackage

// >>> src/sch_top.sv
// supervisory command interpreter for a capacitive keypanel sensor link
// How it works
// - recalibrate pulses recal of scoped keys, only in put mode.
// - recalibrate code 0x62 single byte, echoed back in put mode.
// - echo goes out at once; calibration runs after; progress by error queries.
// - recalibrate during calibration restarts it (fresh pulse).
// - last-command query returns previous byte; repeated query returns 0x6C.
// - reset needs 0x72 then 0x00 within 100 ms in put mode.
// - hard reset about 16 ms after reset echo sent.
// - reset echo not sent means no reset.
// - version query returns version byte.
// - signature query returns fixed part byte.
// - sleep needs 0x5A then 0x00 within 100 ms in put mode.
// - sleep code sent before sleeping and again after waking.
// - first sleep echo stuck for 2 s causes full reset.
// - wake after reset pin low 10 us; second echo; resume in get mode.
// - spi rate operand 0..3 selects master clock maximum.
// - receive path accepts host clock up to 3 MHz whatever rate set.
// - uart rate operand 0..4 selects 9600..57600 baud.
// - new rate applies only after a hard reset (reset command or stuck sleep echo).
// - scope sync output idles low, high around scoped bursts.
// - scope sync default off, volatile, set and read per scope.
// - noise sync put sets flag, get returns it, default off.
// - noise sync change applies after a hard reset (reset command or stuck sleep echo).
// - 0x70 selects put mode, 0x67 get mode, get default.
`timescale 1ns/1ps
`default_nettype none
module sch_top #(
  parameter logic [7:0] VERSION_CODE   = 8'h01, // arbitrary value
  parameter logic [7:0] SIGNATURE_CODE = 8'h5C, // arbitrary value
  parameter int         OPERAND_CYC    = sch_pkg::OPERAND_CYC,
  parameter int         RESET_DLY_CYC  = sch_pkg::RESET_DLY_CYC,
  parameter int         SLEEP_TO_CYC   = sch_pkg::SLEEP_TO_CYC
) (
  input  wire logic               clk_sys_in,
  input  wire logic               arst_n_in,
  input  wire sch_pkg::sch_byte_t rx_in,          // received byte from link
  input  wire logic               tx_ready_in,    // link can take a tx byte
  input  wire logic               uart_mode_in,   // 1 uart, 0 spi
  input  wire logic               rst_pin_n_in,   // device reset pin, async
  input  wire logic               burst_in,       // scoped keys acquiring
  input  wire logic               scope_sync_sel_in, // scoped key sync setting
  output logic                    tx_valid_out,
  output logic [7:0]              tx_data_out,
  output logic                    recal_out,      // one-cycle calibrate restart
  output logic                    scope_sync_wr_out,
  output logic                    scope_sync_val_out,
  output logic                    sync_pin_out,
  output logic [2:0]              rate_active_out,
  output logic                    noise_sync_active_out,
  output logic                    sleep_out,
  output logic                    hard_reset_out
);
  // ==========================================================
  // reset pin synchroniser (three flops, second and third agree)
  // a pin glitch shorter than one clock never counts
  logic       pin_s1_r;
  logic       pin_s2_r;
  logic       pin_s3_r;
  logic       pin_low_r;
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pin_s1_r  <= 1'b1;
      pin_s2_r  <= 1'b1;
      pin_s3_r  <= 1'b1;
      pin_low_r <= 1'b0;
    end else begin
      pin_s1_r <= rst_pin_n_in;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      if (pin_s2_r == pin_s3_r) begin
        pin_low_r <= !pin_s2_r;
      end
    end
  end

  // ==========================================================
  // state
  typedef enum logic [2:0] {
    SCH_IDLE, SCH_WAIT_OP, SCH_RST_ECHO, SCH_RST_DLY,
    SCH_SLP_ECHO, SCH_ASLEEP, SCH_WAKE_ECHO
  } sch_state_t;

  sch_state_t st_r;
  logic [7:0] op_cmd_r;
  logic [31:0] tmr_r;
  logic       put_r;
  logic [7:0] last_r;
  logic [2:0] rate_r;
  logic       noise_r;
  logic       sync_on_r;
  logic       intl_rst_r;

  function automatic logic put_only(input logic [7:0] c);
    put_only = (c == sch_pkg::CMD_RECAL) || (c == sch_pkg::CMD_RESET) ||
               (c == sch_pkg::CMD_SLEEP) || (c == sch_pkg::CMD_RATE);
  endfunction

  wire logic rx_v = rx_in.valid;     // no rate limit on the receive side
  wire logic [7:0] rx_d = rx_in.data;
  // bytes that arrive while an answer is stalled get no answer and are not queued, but still set put/get and the last command
  wire logic tx_busy = tx_valid_out && !tx_ready_in;

  // ==========================================================
  // last command record
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      last_r <= sch_pkg::LAST_RST;
    end else if (intl_rst_r) begin
      last_r <= sch_pkg::LAST_RST;
    end else if (rx_v && st_r == SCH_IDLE) begin
      // operand bytes are not commands, so they are not recorded
      last_r <= rx_d;
    end
  end

  // ==========================================================
  // settings
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      put_r     <= sch_pkg::PUT_MODE_RST;
      rate_r    <= sch_pkg::RATE_RST;
      noise_r   <= sch_pkg::NOISESYNC_RST;
      sync_on_r <= sch_pkg::SCOPESYNC_RST;
    end else if (intl_rst_r) begin
      put_r     <= sch_pkg::PUT_MODE_RST;
      sync_on_r <= sch_pkg::SCOPESYNC_RST;
    end else if (st_r == SCH_WAKE_ECHO) begin
      put_r <= 1'b0;
    end else if (rx_v && st_r == SCH_IDLE) begin
      if (rx_d == sch_pkg::CMD_PUT) put_r <= 1'b1;
      if (rx_d == sch_pkg::CMD_GET) put_r <= 1'b0;
    end else if (rx_v && st_r == SCH_WAIT_OP && put_r) begin
      unique case (op_cmd_r)
        sch_pkg::CMD_RATE: begin
          // an unlisted operand is echoed but leaves the stored rate alone
          if (rx_d <= (uart_mode_in ? sch_pkg::RATE_MAX_UART
                                    : sch_pkg::RATE_MAX_SPI)) begin
            rate_r <= rx_d[2:0];
          end
        end
        sch_pkg::CMD_NOISESYNC: begin
          if (rx_d[7:1] == 7'h00) noise_r <= rx_d[0];
        end
        sch_pkg::CMD_SCOPESYNC: begin
          if (rx_d[7:1] == 7'h00) sync_on_r <= rx_d[0];
        end
        default: ;
      endcase
    end
  end

  // boot-time copy: rate and noise sync only latch on (re)start
  // reloaded on the hard reset too, which is when a new setting may apply
  sch_pkg::sch_boot_cfg_t boot_r;
  logic boot_done_r;
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      boot_r      <= '0;
      boot_done_r <= 1'b0;
    end else if (!boot_done_r || intl_rst_r) begin
      boot_r.rate       <= rate_r;
      boot_r.noise_sync <= noise_r;
      boot_done_r       <= 1'b1;
    end
  end
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rate_active_out       <= sch_pkg::RATE_RST;
      noise_sync_active_out <= sch_pkg::NOISESYNC_RST;
    end else begin
      rate_active_out       <= boot_r.rate;
      noise_sync_active_out <= boot_r.noise_sync;
    end
  end

  // ==========================================================
  // command sequencer and tx
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_r              <= SCH_IDLE;
      op_cmd_r          <= 8'h00;
      tmr_r             <= 32'h0000_0000;
      tx_valid_out      <= 1'b0;
      tx_data_out       <= 8'h00;
      recal_out         <= 1'b0;
      scope_sync_wr_out <= 1'b0;
      scope_sync_val_out<= 1'b0;
      sleep_out         <= 1'b0;
      intl_rst_r        <= 1'b0;
    end else if (intl_rst_r) begin
      // hard reset: volatile state restarts, stored rate and noise sync survive
      st_r              <= SCH_IDLE;
      op_cmd_r          <= 8'h00;
      tmr_r             <= 32'h0000_0000;
      tx_valid_out      <= 1'b0;
      tx_data_out       <= 8'h00;
      recal_out         <= 1'b0;
      scope_sync_wr_out <= 1'b0;
      scope_sync_val_out<= 1'b0;
      sleep_out         <= 1'b0;
      intl_rst_r        <= 1'b0;
    end else begin
      recal_out         <= 1'b0;
      scope_sync_wr_out <= 1'b0;
      if (tx_valid_out && tx_ready_in && st_r != SCH_SLP_ECHO &&
          st_r != SCH_RST_ECHO) begin
        tx_valid_out <= 1'b0;
      end
      unique case (st_r)
        SCH_IDLE: begin
          if (rx_v && !tx_busy) begin
            tx_valid_out <= 1'b1;
            tx_data_out  <= rx_d;          // default echo
            if (rx_d == sch_pkg::CMD_RECAL) begin
              if (put_r) begin
                recal_out <= 1'b1;
              end else begin
                tx_valid_out <= 1'b0;       // no echo in get mode
              end
            end else if (rx_d == sch_pkg::CMD_LAST) begin
              tx_data_out <= (last_r == sch_pkg::CMD_LAST) ? sch_pkg::CMD_LAST
                                                           : last_r;
            end else if (rx_d == sch_pkg::CMD_VERSION) begin
              tx_data_out <= VERSION_CODE;
            end else if (rx_d == sch_pkg::CMD_SIGNATURE) begin
              tx_data_out <= SIGNATURE_CODE;
            end else if (rx_d == sch_pkg::CMD_NOISESYNC && !put_r) begin
              tx_data_out <= {7'h00, noise_r};
            end else if (rx_d == sch_pkg::CMD_SCOPESYNC && !put_r) begin
              tx_data_out <= {7'h00, scope_sync_sel_in};
            end else if (put_r && (rx_d == sch_pkg::CMD_RESET ||
                         rx_d == sch_pkg::CMD_SLEEP || rx_d == sch_pkg::CMD_RATE ||
                         rx_d == sch_pkg::CMD_NOISESYNC ||
                         rx_d == sch_pkg::CMD_SCOPESYNC)) begin
              tx_valid_out <= 1'b0;        // echo after operand
              op_cmd_r     <= rx_d;
              tmr_r        <= 32'h0000_0000;
              st_r         <= SCH_WAIT_OP;
            end else if (put_only(rx_d) && !put_r) begin
              tx_valid_out <= 1'b0;
            end
          end
        end
        SCH_WAIT_OP: begin
          // any byte ends the wait: nothing may come between code and operand
          tmr_r <= tmr_r + 32'h0000_0001;
          if (rx_v) begin
            st_r <= SCH_IDLE;
            if (op_cmd_r == sch_pkg::CMD_RESET && rx_d == sch_pkg::NULL_BYTE) begin
              st_r <= SCH_RST_ECHO;
            end else if (op_cmd_r == sch_pkg::CMD_SLEEP &&
                         rx_d == sch_pkg::NULL_BYTE) begin
              st_r <= SCH_SLP_ECHO;
            end else if (op_cmd_r == sch_pkg::CMD_SCOPESYNC) begin
              tx_valid_out       <= 1'b1;
              tx_data_out        <= op_cmd_r;
              scope_sync_wr_out  <= 1'b1;
              scope_sync_val_out <= rx_d[0];
            end else if (op_cmd_r != sch_pkg::CMD_RESET &&
                         op_cmd_r != sch_pkg::CMD_SLEEP) begin
              tx_valid_out <= 1'b1;
              tx_data_out  <= op_cmd_r;
            end
            tmr_r <= 32'h0000_0000;
          end else if (tmr_r >= 32'(OPERAND_CYC - 1)) begin
            st_r <= SCH_IDLE;              // abandoned
          end
        end
        SCH_RST_ECHO: begin
          // the echo must leave first, else the host never learns of the reset
          tx_valid_out <= 1'b1;
          tx_data_out  <= sch_pkg::CMD_RESET;
          tmr_r        <= tmr_r + 32'h0000_0001;
          if (tx_ready_in) begin
            tx_valid_out <= 1'b0;
            tmr_r        <= 32'h0000_0000;
            st_r         <= SCH_RST_DLY;
          end else if (tmr_r >= 32'(OPERAND_CYC - 1)) begin
            tx_valid_out <= 1'b0;          // give up, no reset
            st_r         <= SCH_IDLE;
          end
        end
        SCH_RST_DLY: begin
          tmr_r <= tmr_r + 32'h0000_0001;
          if (tmr_r >= 32'(RESET_DLY_CYC - 1)) begin
            intl_rst_r <= 1'b1;
          end
        end
        SCH_SLP_ECHO: begin
          // a host that never takes the echo must not lock the device up
          tx_valid_out <= 1'b1;
          tx_data_out  <= sch_pkg::CMD_SLEEP;
          tmr_r        <= tmr_r + 32'h0000_0001;
          if (tx_ready_in) begin
            tx_valid_out <= 1'b0;
            sleep_out    <= 1'b1;
            tmr_r        <= 32'h0000_0000;
            st_r         <= SCH_ASLEEP;
          end else if (tmr_r >= 32'(SLEEP_TO_CYC - 1)) begin
            intl_rst_r <= 1'b1;            // stuck slave select
          end
        end
        SCH_ASLEEP: begin
          // the wake count restarts whenever the pin goes high again
          tmr_r <= pin_low_r ? tmr_r + 32'h0000_0001 : 32'h0000_0000;
          if (pin_low_r && tmr_r >= 32'(sch_pkg::WAKE_LOW_CYC - 1)) begin
            sleep_out <= 1'b0;
            st_r      <= SCH_WAKE_ECHO;
          end
        end
        SCH_WAKE_ECHO: begin
          // the host learns of the wake only from this second echo
          tx_valid_out <= 1'b1;
          tx_data_out  <= sch_pkg::CMD_SLEEP;
          st_r         <= SCH_IDLE;
        end
      endcase
    end
  end

  // one-cycle strobe telling the keys and the link to restart
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      hard_reset_out <= 1'b0;
    end else begin
      hard_reset_out <= intl_rst_r;
    end
  end

  // ==========================================================
  // scope sync pin: bursts are the scoped keys' own, so no per-key work here
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sync_pin_out <= 1'b0;
    end else begin
      sync_pin_out <= (sync_on_r || scope_sync_sel_in) && burst_in;
    end
  end
  // receive bytes come in already framed, at whatever rate the host chose
endmodule
`default_nettype wire

// >>> test/sch_host_model.sv
// host model: takes echo bytes from the handler after a chosen lag
`timescale 1ns/1ps
`default_nettype none
module sch_host_model (
  input  wire logic       clk_in,
  input  wire logic       arst_n_in,
  input  wire logic       tx_valid_in,
  input  wire logic [7:0] tx_data_in,
  input  wire logic [3:0] lag_in,
  input  wire logic       hold_in,
  output logic            tx_ready_out,
  output logic            got_out,
  output logic [7:0]      got_byte_out
);
  logic [3:0] wait_r;
  logic [1:0] gap_r;
  // ==========================================
  // accept path
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tx_ready_out <= 1'b0;
      got_out <= 1'b0;
      got_byte_out <= 8'h00;
      wait_r <= 4'h0;
      gap_r <= 2'h0;
    end else begin
      got_out <= 1'b0;
      if (tx_ready_out) begin
        tx_ready_out <= 1'b0;
        got_out <= tx_valid_in;
        got_byte_out <= tx_data_in;
        gap_r <= 2'h2;
      end else if (gap_r != 2'h0) begin
        // let the valid drop before looking again
        gap_r <= gap_r - 2'h1;
      end else if (tx_valid_in && !hold_in) begin
        if (wait_r >= lag_in) begin
          tx_ready_out <= 1'b1;
          wait_r <= 4'h0;
        end else begin
          wait_r <= wait_r + 4'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> test/sch_top_assertions.sv
// checker: port assertions for the command handler
`timescale 1ns/1ps
`default_nettype none
module sch_top_assertions #(
  parameter int OPERAND_CYC   = 50,
  parameter int RESET_DLY_CYC = 20,
  parameter int SLEEP_TO_CYC  = 100
) (
  input wire logic               clk_sys_in,
  input wire logic               arst_n_in,
  input wire sch_pkg::sch_byte_t rx_in,
  input wire logic               tx_ready_in,
  input wire logic               rst_pin_n_in,
  input wire logic               burst_in,
  input wire logic               scope_sync_sel_in,
  input wire logic               tx_valid_out,
  input wire logic [7:0]         tx_data_out,
  input wire logic               recal_out,
  input wire logic               sync_pin_out,
  input wire logic [2:0]         rate_active_out,
  input wire logic               noise_sync_active_out,
  input wire logic               sleep_out,
  input wire logic               hard_reset_out
);
  logic [7:0]  acc_r;
  logic [15:0] rcnt_r;
  logic [8:0]  lcnt_r;
  logic [1:0]  up_r;
  // ==========================================
  // helpers: last byte taken, time since reset echo, pin low time
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      acc_r <= 8'h00;
      rcnt_r <= 16'h0000;
      up_r <= 2'h0;
    end else begin
      if (tx_valid_out && tx_ready_in) acc_r <= tx_data_out;
      if (tx_valid_out && tx_ready_in && tx_data_out == sch_pkg::CMD_RESET) rcnt_r <= 16'h0001;
      else if (hard_reset_out) rcnt_r <= 16'h0000;
      else if (rcnt_r != 16'h0000 && rcnt_r != 16'hFFFF) rcnt_r <= rcnt_r + 16'h0001;
      // the hard reset restarts the block and reloads its settings
      if (hard_reset_out) up_r <= 2'h0;
      else if (up_r != 2'h3) up_r <= up_r + 2'h1;
    end
  end
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) lcnt_r <= 9'h000;
    else if (rst_pin_n_in) lcnt_r <= 9'h000;
    else if (lcnt_r != 9'h1FF) lcnt_r <= lcnt_r + 9'h001;
  end
  // ==========================================
  // assertions
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!arst_n_in);
  a_recal_echo: assert property (
    recal_out |-> tx_valid_out && tx_data_out == sch_pkg::CMD_RECAL
      && $past(rx_in.valid) && $past(rx_in.data) == sch_pkg::CMD_RECAL)
    else $error("calibrate pulse without its echo");
  a_tx_hold: assert property (
    tx_valid_out && !tx_ready_in && tx_data_out != sch_pkg::CMD_RESET
      |=> (tx_valid_out && $stable(tx_data_out)) || hard_reset_out)
    else $error("answer byte withdrawn before taken");
  a_sync_on: assert property (burst_in && scope_sync_sel_in |=> sync_pin_out)
    else $error("sync pin low during enabled burst");
  a_sync_idle: assert property (sync_pin_out |-> $past(burst_in))
    else $error("sync pin high outside burst");
  a_reset_delay: assert property (
    $rose(hard_reset_out) && rcnt_r != 16'h0000
      |-> rcnt_r >= RESET_DLY_CYC && rcnt_r <= RESET_DLY_CYC + 2)
    else $error("hard reset at wrong distance from echo");
  a_sleep_entry: assert property ($rose(sleep_out) |-> acc_r == sch_pkg::CMD_SLEEP)
    else $error("sleep entered before echo taken");
  a_wake_low: assert property ($fell(sleep_out) |-> lcnt_r >= 9'h0FA)
    else $error("woke before pin low long enough");
  a_wake_echo: assert property (
    $fell(sleep_out) |-> ##[0:8] (tx_valid_out && tx_data_out == sch_pkg::CMD_SLEEP))
    else $error("no second sleep echo after wake");
  a_cfg_frozen: assert property (
    up_r == 2'h3 |-> $stable(rate_active_out) && $stable(noise_sync_active_out))
    else $error("active settings changed without reset");
endmodule
bind sch_top sch_top_assertions #(.OPERAND_CYC(OPERAND_CYC), .RESET_DLY_CYC(RESET_DLY_CYC),
  .SLEEP_TO_CYC(SLEEP_TO_CYC)) u_sch_top_assertions (.clk_sys_in(clk_sys_in),
  .arst_n_in(arst_n_in), .rx_in(rx_in), .tx_ready_in(tx_ready_in),
  .rst_pin_n_in(rst_pin_n_in), .burst_in(burst_in), .scope_sync_sel_in(scope_sync_sel_in),
  .tx_valid_out(tx_valid_out), .tx_data_out(tx_data_out), .recal_out(recal_out),
  .sync_pin_out(sync_pin_out), .rate_active_out(rate_active_out),
  .noise_sync_active_out(noise_sync_active_out), .sleep_out(sleep_out),
  .hard_reset_out(hard_reset_out));
`default_nettype wire

// >>> test/sch_top_tb.sv
// testbench: command handler against the host model
`timescale 1ns/1ps
`default_nettype none
module sch_top_tb;
  localparam int OPC = 50;
  localparam int RDC = 20;
  localparam int STC = 100;
  localparam logic [7:0] VER = 8'h3A; // arbitrary value
  localparam logic [7:0] SIG = 8'hA5; // arbitrary value
  logic clk_sys_in = 1'b0;
  logic arst_n_in = 1'b0;
  sch_pkg::sch_byte_t rx = '0;
  logic uart = 1'b0, pin_n = 1'b1, burst = 1'b0, sel = 1'b0, hold = 1'b0;
  logic tx_rdy, tx_v, recal, sync, nsa, slp, hrst, got_p;
  logic [7:0] tx_d, got_b, op;
  logic [3:0] lag = 4'h0;
  logic [2:0] rate_a, exp_rate;
  logic [7:0] got_q[$];
  int fails = 0, samples_checked = 0, recals = 0, hrsts = 0;
  always #20 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) if (got_p === 1'b1) got_q.push_back(got_b);
  always @(posedge clk_sys_in) if (recal === 1'b1) recals++;
  always @(posedge clk_sys_in) if (hrst === 1'b1) hrsts++;
  sch_top #(.VERSION_CODE(VER), .SIGNATURE_CODE(SIG), .OPERAND_CYC(OPC),
    .RESET_DLY_CYC(RDC), .SLEEP_TO_CYC(STC)) u_sch_top (.clk_sys_in(clk_sys_in),
    .arst_n_in(arst_n_in), .rx_in(rx), .tx_ready_in(tx_rdy), .uart_mode_in(uart),
    .rst_pin_n_in(pin_n), .burst_in(burst), .scope_sync_sel_in(sel), .tx_valid_out(tx_v),
    .tx_data_out(tx_d), .recal_out(recal), .scope_sync_wr_out(), .scope_sync_val_out(),
    .sync_pin_out(sync), .rate_active_out(rate_a), .noise_sync_active_out(nsa),
    .sleep_out(slp), .hard_reset_out(hrst));
  sch_host_model u_sch_host_model (.clk_in(clk_sys_in), .arst_n_in(arst_n_in),
    .tx_valid_in(tx_v), .tx_data_in(tx_d), .lag_in(lag), .hold_in(hold),
    .tx_ready_out(tx_rdy), .got_out(got_p), .got_byte_out(got_b));
  // ==========================================
  // tasks
  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask
  task automatic rst();
    arst_n_in <= 1'b0;
    tick(16);
    arst_n_in <= 1'b1;
    tick(2);
    got_q.delete();
  endtask
  task automatic put(input logic [7:0] b);
    @(posedge clk_sys_in);
    rx <= {1'b1, b};
    @(posedge clk_sys_in);
    rx <= '0;
  endtask
  task automatic echo(input logic [7:0] e);
    int n;
    n = 0;
    while (got_q.size() == 0 && n < 300) begin
      tick(1);
      n++;
    end
    chk("echo", e, got_q.size() != 0 ? got_q.pop_front() : 8'hxx);
  endtask
  task automatic nil();
    tick(30);
    chk("silence", 8'h00, 8'(got_q.size()));
  endtask
  task automatic ask(input logic [7:0] c, input logic [7:0] e);
    lag <= 4'($urandom_range(4));
    put(c);
    echo(e);
  endtask
  task automatic ask2(input logic [7:0] c, input logic [7:0] o, input logic [7:0] e);
    put(c);
    put(o);
    echo(e);
  endtask
  task automatic close_out();
    if (fails == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ==========================================
  // watchdog: whole sequence needs well under two thousand cycles
  initial begin
    tick(20000);
    fails++;
    close_out();
  end
  // ==========================================
  // main sequence
  initial begin
    void'($urandom(15));
    exp_rate = 3'h0;
    rst();
    put(sch_pkg::CMD_RECAL);
    nil();
    ask(sch_pkg::CMD_LAST, sch_pkg::CMD_RECAL);
    ask(sch_pkg::CMD_LAST, sch_pkg::CMD_LAST);
    ask(sch_pkg::CMD_VERSION, VER);
    ask(sch_pkg::CMD_SIGNATURE, SIG);
    ask(sch_pkg::CMD_PUT, sch_pkg::CMD_PUT);
    ask(sch_pkg::CMD_RECAL, sch_pkg::CMD_RECAL);
    ask(sch_pkg::CMD_RECAL, sch_pkg::CMD_RECAL);
    chk("recal count", 8'h02, 8'(recals));
    ask2(sch_pkg::CMD_NOISESYNC, 8'h01, sch_pkg::CMD_NOISESYNC);
    for (int i = 0; i < 12; i++) begin
      op = 8'($urandom_range(6));
      uart <= 1'($urandom_range(1));
      ask2(sch_pkg::CMD_RATE, op, sch_pkg::CMD_RATE);
      if (op <= (uart ? sch_pkg::RATE_MAX_UART : sch_pkg::RATE_MAX_SPI)) exp_rate = op[2:0];
    end
    chk("rate early", 8'h00, {5'h0, rate_a});
    chk("noise early", 8'h00, {7'h0, nsa});
    for (int i = 0; i < 16; i++) begin
      @(posedge clk_sys_in);
      burst <= 1'($urandom_range(1));
      sel <= 1'($urandom_range(1));
      tick(2);
      #1;
      chk("sync", {7'h0, burst & sel}, {7'h0, sync});
    end
    ask2(sch_pkg::CMD_SCOPESYNC, 8'h01, sch_pkg::CMD_SCOPESYNC);
    burst <= 1'b1;
    sel <= 1'b0;
    tick(3);
    chk("sync on", 8'h01, {7'h0, sync});
    burst <= 1'b0;
    ask(sch_pkg::CMD_GET, sch_pkg::CMD_GET);
    ask(sch_pkg::CMD_NOISESYNC, 8'h01);
    ask(sch_pkg::CMD_PUT, sch_pkg::CMD_PUT);
    put(sch_pkg::CMD_RESET);
    tick(OPC + 10);
    put(sch_pkg::NULL_BYTE);
    tick(RDC + 40);
    chk("late operand", 8'h00, 8'(hrsts));
    got_q.delete();
    hold <= 1'b1;
    put(sch_pkg::CMD_RESET);
    put(sch_pkg::NULL_BYTE);
    tick(OPC + RDC + 40);
    chk("echo stuck", 8'h00, 8'(hrsts));
    hold <= 1'b0;
    tick(10);
    got_q.delete();
    ask2(sch_pkg::CMD_RESET, sch_pkg::NULL_BYTE, sch_pkg::CMD_RESET);
    tick(RDC + 5);
    chk("hard reset", 8'h01, 8'(hrsts));
    chk("rate active", {5'h0, exp_rate}, {5'h0, rate_a});
    chk("noise active", 8'h01, {7'h0, nsa});
    ask(sch_pkg::CMD_PUT, sch_pkg::CMD_PUT);
    ask2(sch_pkg::CMD_SLEEP, sch_pkg::NULL_BYTE, sch_pkg::CMD_SLEEP);
    tick(5);
    chk("asleep", 8'h01, {7'h0, slp});
    pin_n <= 1'b0;
    tick(300);
    pin_n <= 1'b1;
    echo(sch_pkg::CMD_SLEEP);
    chk("awake", 8'h00, {7'h0, slp});
    put(sch_pkg::CMD_RECAL);
    nil();
    ask(sch_pkg::CMD_PUT, sch_pkg::CMD_PUT);
    hold <= 1'b1;
    put(sch_pkg::CMD_SLEEP);
    put(sch_pkg::NULL_BYTE);
    tick(STC + 30);
    chk("sleep stuck", 8'h02, 8'(hrsts));
    hold <= 1'b0;
    rst();
    close_out();
  end
endmodule
`default_nettype wire
